// [core/hufc_params.svh]
`ifndef HUFC_PARAMS_SVH
`define HUFC_PARAMS_SVH

// system clock
`define HUFC_CLK_HZ 50000000
`define HUFC_CLK_PERIOD_NS 20

// bit rate limits and default, in bits per second
`define HUFC_BAUD_DEFAULT 115200
`define HUFC_BAUD_MIN 9600
`define HUFC_BAUD_MAX 921600

// clock cycles per bit
`define HUFC_DIV_W 16
`define HUFC_DIV_DEFAULT (`HUFC_CLK_HZ / `HUFC_BAUD_DEFAULT)
`define HUFC_DIV_MAX (`HUFC_CLK_HZ / `HUFC_BAUD_MIN)
`define HUFC_DIV_MIN (`HUFC_CLK_HZ / `HUFC_BAUD_MAX)

// character format
`define HUFC_DATA_BITS 8
`define HUFC_BITS_PER_CHAR 10

// idle gap between transmissions, in character times
`define HUFC_GAP_DEFAULT 12

// receive timeout limit, in character times
`define HUFC_TIMEOUT_DEFAULT 4

// receive frame buffer
`define HUFC_RXBUF_DEPTH 8
`define HUFC_RXBUF_AW 3
`define HUFC_RTS_SLACK 4

// time from reset release to pin assignment
`define HUFC_BOOT_TIME_NS 1000
`define HUFC_BOOT_CYCLES \
  ((`HUFC_BOOT_TIME_NS + `HUFC_CLK_PERIOD_NS - 1) / `HUFC_CLK_PERIOD_NS)

// serial channels
`define HUFC_CHANNELS 2

`endif

// [core/hufc_pkg.sv]
`include "hufc_params.svh"

package hufc_pkg;

  typedef struct packed {
    logic [`HUFC_DIV_W-1:0] bit_div;
    logic [7:0] gap_chars;
    logic [7:0] timeout_chars;
  } hufc_cfg_t;

  typedef struct packed {
    logic timeout;
    logic overrun;
    logic framing;
  } hufc_err_t;

  typedef enum logic [2:0] {
    TX_IDLE,
    TX_START,
    TX_DATA,
    TX_STOP,
    TX_GAP
  } hufc_tx_state_t;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } hufc_rx_state_t;

endpackage

// [core/hufc_serial_rx.sv]
`timescale 1ns/1ps
`default_nettype none
`include "hufc_params.svh"

module hufc_serial_rx
  import hufc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic serial_in,
  input wire logic [`HUFC_DIV_W-1:0] bit_div,
  input wire logic [7:0] timeout_chars,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic rx_hold,
  output hufc_err_t rx_err
);

  hufc_rx_state_t state_reg;
  logic [`HUFC_DIV_W-1:0] cnt_reg;
  logic [2:0] bit_reg;
  logic [7:0] shift_reg;
  logic [7:0] mem [`HUFC_RXBUF_DEPTH];
  logic [`HUFC_RXBUF_AW-1:0] wr_reg;
  logic [`HUFC_RXBUF_AW-1:0] rd_reg;
  logic [`HUFC_RXBUF_AW:0] fill_reg;
  logic [`HUFC_DIV_W-1:0] idle_cnt_reg;
  logic [11:0] idle_bits_reg;
  logic armed_reg;
  logic frame_done;
  logic frame_ok;
  logic push;
  logic pop;
  logic full;
  logic [11:0] limit_bits;

  assign full = fill_reg == (`HUFC_RXBUF_AW+1)'(`HUFC_RXBUF_DEPTH);
  assign frame_done = state_reg == RX_STOP && cnt_reg == '0;
  assign frame_ok = frame_done && serial_in;
  assign push = frame_ok && !full;
  assign pop = rx_valid && rx_ready;
  assign rx_valid = fill_reg != '0;
  assign rx_data = mem[rd_reg];
  assign limit_bits = 12'(timeout_chars * `HUFC_BITS_PER_CHAR);

  //////////////////////////////////////////////////////////////////////////
  // frame sampler: half a bit into start, then once per bit

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= RX_IDLE;
      cnt_reg <= '0;
      bit_reg <= '0;
      shift_reg <= '0;
    end else begin
      case (state_reg)
        RX_IDLE: begin
          if (!serial_in) begin
            state_reg <= RX_START;
            cnt_reg <= bit_div >> 1;
          end
        end
        RX_START: begin
          if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
          end else if (serial_in) begin
            state_reg <= RX_IDLE;
          end else begin
            state_reg <= RX_DATA;
            cnt_reg <= bit_div - 1'b1;
            bit_reg <= '0;
          end
        end
        RX_DATA: begin
          if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
          end else begin
            shift_reg <= {serial_in, shift_reg[7:1]}; // lsb first
            cnt_reg <= bit_div - 1'b1;
            bit_reg <= bit_reg + 1'b1;
            if (bit_reg == 3'(`HUFC_DATA_BITS - 1)) begin
              state_reg <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
          end else begin
            state_reg <= RX_IDLE;
          end
        end
        default: state_reg <= RX_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // receive frame buffer

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_reg] <= shift_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      fill_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
      fill_reg <= fill_reg + (`HUFC_RXBUF_AW+1)'(push)
                - (`HUFC_RXBUF_AW+1)'(pop);
    end
  end

  // hold off the sender while no more than the in-flight slack slots remain
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_hold <= 1'b0;
    end else begin
      rx_hold <= fill_reg >= (`HUFC_RXBUF_AW+1)'(
        `HUFC_RXBUF_DEPTH - `HUFC_RTS_SLACK);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // interval timer between frames

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      idle_cnt_reg <= '0;
      idle_bits_reg <= '0;
      armed_reg <= 1'b0;
    end else if (frame_done) begin
      idle_cnt_reg <= '0;
      idle_bits_reg <= '0;
      armed_reg <= 1'b1;
    end else if (state_reg != RX_IDLE) begin
      armed_reg <= 1'b0;
    end else if (armed_reg) begin
      if (idle_cnt_reg >= bit_div - 1'b1) begin
        idle_cnt_reg <= '0;
        idle_bits_reg <= idle_bits_reg + 1'b1;
      end else begin
        idle_cnt_reg <= idle_cnt_reg + 1'b1;
      end
      if (idle_bits_reg >= limit_bits) begin
        armed_reg <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // error pulses

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_err <= '0;
    end else begin
      rx_err.timeout <= armed_reg && state_reg == RX_IDLE && !frame_done
                        && idle_bits_reg >= limit_bits;
      rx_err.overrun <= frame_ok && full;
      rx_err.framing <= frame_done && !serial_in;
    end
  end

endmodule

`default_nettype wire

// [core/hufc_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "hufc_params.svh"

module hufc_top
  import hufc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic module_reset_n,
  input wire logic ch1_serial_in,
  output logic ch1_serial_out,
  output logic ch1_serial_out_oe,
  input wire logic tx_permit_n,
  output logic rx_request_n,
  output logic rx_request_n_oe,
  input wire logic ch2_serial_in,
  output logic ch2_serial_out,
  output logic ch2_serial_out_oe,
  input wire logic cfg_load,
  input wire hufc_cfg_t cfg_in,
  output logic cfg_reject,
  output hufc_cfg_t cfg_active,
  input wire logic [`HUFC_CHANNELS-1:0][7:0] tx_data,
  input wire logic [`HUFC_CHANNELS-1:0] tx_valid,
  output logic [`HUFC_CHANNELS-1:0] tx_ready,
  output logic [`HUFC_CHANNELS-1:0][7:0] rx_data,
  output logic [`HUFC_CHANNELS-1:0] rx_valid,
  input wire logic [`HUFC_CHANNELS-1:0] rx_ready,
  output hufc_err_t [`HUFC_CHANNELS-1:0] rx_err,
  output logic boot_done
);

  localparam int PINS = 4;
  localparam logic [7:0] BOOT_LAST = 8'(`HUFC_BOOT_CYCLES - 1);
  localparam logic [`HUFC_DIV_W-1:0] DIV_LO = `HUFC_DIV_W'(`HUFC_DIV_MIN);
  localparam logic [`HUFC_DIV_W-1:0] DIV_HI = `HUFC_DIV_W'(`HUFC_DIV_MAX);

  logic [PINS-1:0] pin_meta_reg;
  logic [PINS-1:0] pin_sync_reg;
  logic [PINS-1:0] pin_raw;
  logic host_reset;
  logic core_rst;
  logic [7:0] boot_cnt_reg;
  logic permit_n;
  logic [`HUFC_CHANNELS-1:0] serial_in_s;
  logic [`HUFC_CHANNELS-1:0] serial_out;
  logic [`HUFC_CHANNELS-1:0] rx_hold;
  logic [11:0] gap_bits;
  logic div_ok;

  //////////////////////////////////////////////////////////////////////////
  // pin input synchronisers

  assign pin_raw = {module_reset_n, tx_permit_n, ch2_serial_in, ch1_serial_in};

  // first stage: may go metastable, read only by the second stage
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_meta_reg <= '1;
    end else begin
      pin_meta_reg <= pin_raw;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_sync_reg <= '1;
    end else begin
      pin_sync_reg <= pin_meta_reg;
    end
  end

  assign host_reset = !pin_sync_reg[3];
  assign core_rst = rst || host_reset;
  assign permit_n = pin_sync_reg[2];

  //////////////////////////////////////////////////////////////////////////
  // boot: pins stay released until the serial functions are attached

  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      boot_cnt_reg <= '0;
    end else if (boot_cnt_reg != BOOT_LAST) begin
      boot_cnt_reg <= boot_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      boot_done <= 1'b0;
    end else if (boot_cnt_reg == BOOT_LAST) begin
      boot_done <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // rate, gap and timeout settings

  assign div_ok = cfg_in.bit_div >= DIV_LO && cfg_in.bit_div <= DIV_HI;

  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      cfg_active.bit_div <= `HUFC_DIV_W'(`HUFC_DIV_DEFAULT);
      cfg_active.gap_chars <= 8'(`HUFC_GAP_DEFAULT);
      cfg_active.timeout_chars <= 8'(`HUFC_TIMEOUT_DEFAULT);
    end else if (cfg_load && div_ok) begin
      cfg_active <= cfg_in;
    end
  end

  // an out-of-range divisor leaves the settings untouched
  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      cfg_reject <= 1'b0;
    end else begin
      cfg_reject <= cfg_load && !div_ok;
    end
  end

  assign gap_bits = 12'(cfg_active.gap_chars * `HUFC_BITS_PER_CHAR);

  //////////////////////////////////////////////////////////////////////////
  // per channel transmitter and receiver

  for (genvar ch = 0; ch < `HUFC_CHANNELS; ch++) begin : g_chan
    hufc_tx_state_t state_reg;
    logic [`HUFC_DIV_W-1:0] cnt_reg;
    logic [2:0] bit_reg;
    logic [7:0] shift_reg;
    logic [11:0] gap_reg;
    logic out_reg;
    logic permitted;
    logic bit_end;

    // only the first channel has a transmit handshake
    assign permitted = (ch == 0) ? !permit_n : 1'b1;
    assign bit_end = cnt_reg == '0;
    // permit is looked at only before a start bit
    assign tx_ready[ch] = boot_done && state_reg == TX_IDLE
                          && permitted;

    always_ff @(posedge clk_sys) begin
      if (core_rst) begin
        state_reg <= TX_IDLE;
        cnt_reg <= '0;
        bit_reg <= '0;
        shift_reg <= '0;
        gap_reg <= '0;
        out_reg <= 1'b1;
      end else begin
        case (state_reg)
          TX_IDLE: begin
            out_reg <= 1'b1;
            if (tx_valid[ch] && tx_ready[ch]) begin
              shift_reg <= tx_data[ch];
              cnt_reg <= cfg_active.bit_div - 1'b1;
              out_reg <= 1'b0;
              state_reg <= TX_START;
            end
          end
          TX_START: begin
            if (!bit_end) begin
              cnt_reg <= cnt_reg - 1'b1;
            end else begin
              cnt_reg <= cfg_active.bit_div - 1'b1;
              out_reg <= shift_reg[0];
              shift_reg <= shift_reg >> 1;
              bit_reg <= '0;
              state_reg <= TX_DATA;
            end
          end
          TX_DATA: begin
            if (!bit_end) begin
              cnt_reg <= cnt_reg - 1'b1;
            end else begin
              cnt_reg <= cfg_active.bit_div - 1'b1;
              bit_reg <= bit_reg + 1'b1;
              if (bit_reg == 3'(`HUFC_DATA_BITS - 1)) begin
                out_reg <= 1'b1;
                state_reg <= TX_STOP;
              end else begin
                out_reg <= shift_reg[0];
                shift_reg <= shift_reg >> 1;
              end
            end
          end
          TX_STOP: begin
            if (!bit_end) begin
              cnt_reg <= cnt_reg - 1'b1;
            end else if (tx_valid[ch] && permitted) begin
              state_reg <= TX_IDLE; // same transmission continues
            end else begin
              cnt_reg <= cfg_active.bit_div - 1'b1;
              gap_reg <= gap_bits;
              state_reg <= TX_GAP;
            end
          end
          TX_GAP: begin
            out_reg <= 1'b1;
            if (gap_reg == '0) begin
              state_reg <= TX_IDLE;
            end else if (!bit_end) begin
              cnt_reg <= cnt_reg - 1'b1;
            end else begin
              cnt_reg <= cfg_active.bit_div - 1'b1;
              gap_reg <= gap_reg - 1'b1;
            end
          end
          default: state_reg <= TX_IDLE;
        endcase
      end
    end

    assign serial_out[ch] = out_reg;
    // line reads idle until the pins are handed to the receiver
    assign serial_in_s[ch] = boot_done ? pin_sync_reg[ch] : 1'b1;

    hufc_serial_rx u_rx (
      .clk_sys(clk_sys),
      .rst(core_rst),
      .serial_in(serial_in_s[ch]),
      .bit_div(cfg_active.bit_div),
      .timeout_chars(cfg_active.timeout_chars),
      .rx_data(rx_data[ch]),
      .rx_valid(rx_valid[ch]),
      .rx_ready(rx_ready[ch]),
      .rx_hold(rx_hold[ch]),
      .rx_err(rx_err[ch])
    );
  end

  //////////////////////////////////////////////////////////////////////////
  // pin drivers

  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      ch1_serial_out <= 1'b1;
      ch2_serial_out <= 1'b1;
    end else begin
      ch1_serial_out <= serial_out[0];
      ch2_serial_out <= serial_out[1];
    end
  end

  // pins stay released until boot has attached the serial functions
  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      ch1_serial_out_oe <= 1'b0;
      ch2_serial_out_oe <= 1'b0;
      rx_request_n_oe <= 1'b0;
    end else begin
      ch1_serial_out_oe <= boot_done;
      ch2_serial_out_oe <= boot_done;
      rx_request_n_oe <= boot_done;
    end
  end

  // only the first channel's receiver asks the host to hold off
  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      rx_request_n <= 1'b1;
    end else begin
      rx_request_n <= !boot_done || rx_hold[0];
    end
  end

endmodule

`default_nettype wire

// [sim/hufc_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module hufc_host_model (
  input wire logic clk_sys,
  input wire logic [15:0] div,
  input wire logic line_in,
  input wire logic flow_n,
  output logic line_out
);
  logic [7:0] got_q[$];
  initial line_out = 1'b1;
  ////////////////////////////////////////
  task automatic send(input logic [7:0] b, input bit ok, input bit obey);
    logic [9:0] f;
    int n;
    f = {ok, b, 1'b0};
    n = 0;
    while (obey && flow_n !== 1'b0 && n < 20000) begin
      @(posedge clk_sys);
      n++;
    end
    @(posedge clk_sys);
    for (int i = 0; i < 11; i++) begin
      #1 line_out = (i < 10) ? f[i] : 1'b1;
      repeat (div) @(posedge clk_sys);
    end
  endtask
  ////////////////////////////////////////
  always begin
    logic [7:0] b;
    @(negedge line_in);
    repeat (div / 2) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      repeat (div) @(posedge clk_sys);
      b[i] = line_in;
    end
    repeat (div) @(posedge clk_sys);
    if (line_in === 1'b1)
      got_q.push_back(b);
  end
endmodule
`default_nettype wire

// [sim/hufc_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module hufc_tb_top
  import hufc_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic module_reset_n = 1'b1;
  logic tx_permit_n = 1'b0;
  logic cfg_load = 1'b0;
  hufc_cfg_t cfg_in = '0;
  hufc_cfg_t cfg_active;
  logic cfg_reject, boot_done, s1_in, s1_out, s1_oe, s2_in, s2_out, s2_oe;
  logic rts_n, rts_oe;
  logic [1:0][7:0] tx_data = '0;
  logic [1:0][7:0] rx_data;
  logic [1:0] tx_valid = '0;
  logic [1:0] rx_ready = '0;
  logic [1:0] tx_ready, rx_valid;
  hufc_err_t [1:0] rx_err;
  logic [15:0] div = 16'h01b2;
  logic [15:0] bd[3] = '{16'h0035, 16'h1459, 16'h0036};
  logic [7:0] exp_q[$];
  logic [7:0] sq[$];
  logic [7:0] got[$];
  logic [7:0] b;
  int failures = 0;
  int checks = 0;
  int n_to = 0;
  int n_ov = 0;
  int n_fr = 0;
  int n_e2 = 0;
  int n_t2 = 0;
  int cyc = 0;
  int t0, c;
  wire l1 = s1_oe ? s1_out : 1'b1;
  wire l2 = s2_oe ? s2_out : 1'b1;
  wire rts_w = rts_oe ? rts_n : 1'b1;

  hufc_top hufc_top_i (.clk_sys(clk_sys), .rst(rst),
    .module_reset_n(module_reset_n), .ch1_serial_in(s1_in),
    .ch1_serial_out(s1_out), .ch1_serial_out_oe(s1_oe),
    .tx_permit_n(tx_permit_n), .rx_request_n(rts_n),
    .rx_request_n_oe(rts_oe), .ch2_serial_in(s2_in),
    .ch2_serial_out(s2_out), .ch2_serial_out_oe(s2_oe),
    .cfg_load(cfg_load), .cfg_in(cfg_in), .cfg_reject(cfg_reject),
    .cfg_active(cfg_active), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_err(rx_err), .boot_done(boot_done));
  hufc_host_model h1 (.clk_sys(clk_sys), .div(div), .line_in(l1),
    .flow_n(rts_w), .line_out(s1_in));
  hufc_host_model h2 (.clk_sys(clk_sys), .div(div), .line_in(l2),
    .flow_n(1'b0), .line_out(s2_in));

  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    n_to <= n_to + rx_err[0].timeout;
    n_ov <= n_ov + rx_err[0].overrun;
    n_fr <= n_fr + rx_err[0].framing;
    n_e2 <= n_e2 + (rx_err[1].overrun | rx_err[1].framing);
    n_t2 <= n_t2 + rx_err[1].timeout;
  end
  ////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input string what, input logic [31:0] e,
      input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %0h seen %0h", what, e, g);
    end
  endtask
  task automatic test_done;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic dev_tx(input int ch, input logic [7:0] v);
    int n;
    n = 0;
    tx_data[ch] = v;
    tx_valid[ch] = 1'b1;
    while (tx_ready[ch] !== 1'b1 && n < 30000) begin
      tick(1);
      n++;
    end
    tick(1);
  endtask
  task automatic cmp_tx(input int ch);
    if (ch)
      got = h2.got_q;
    else
      got = h1.got_q;
    chk("tx_count", exp_q.size(), got.size());
    foreach (exp_q[i]) chk("tx_byte", exp_q[i], got[i]);
    exp_q.delete();
    h1.got_q.delete();
    h2.got_q.delete();
  endtask
  task automatic drain(input int ch, input int n);
    int w;
    for (int i = 0; i < n; i++) begin
      w = 0;
      while (rx_valid[ch] !== 1'b1 && w < 3000) begin
        tick(1);
        w++;
      end
      chk("rx_byte", exp_q.pop_front(), rx_data[ch]);
      rx_ready[ch] = 1'b1;
      tick(1);
      rx_ready[ch] = 1'b0;
      tick(1);
    end
  endtask
  task automatic put(input int n);
    for (int i = 0; i < n; i++) begin
      b = 8'($urandom);
      exp_q.push_back(b);
    end
  endtask
  ////////////////////////////////////////
  initial begin
    void'($urandom(32'h7881ebb7));
    tick(4);
    chk("cfg_reset", {16'h01b2, 8'h0c, 8'h04}, cfg_active);
    chk("oe_reset", 3'h0, {s1_oe, s2_oe, rts_oe});
    rst = 1'b0;
    tick(40);
    chk("boot_early", 1'b0, boot_done);
    tick(20);
    chk("boot_pins", 4'hf, {boot_done, s1_oe, s2_oe, rts_oe});
    chk("request_boot", 1'b0, rts_w);
    for (int i = 0; i < 3; i++) begin
      cfg_in = {bd[i], 8'h01, 8'h02};
      cfg_load = 1'b1;
      tick(1);
      cfg_load = 1'b0;
      chk("cfg_reject", i < 2, cfg_reject);
      tick(1);
    end
    chk("cfg_new", {16'h0036, 8'h01, 8'h02}, cfg_active);
    div = 16'h0036;
    for (c = 0; c < 2; c++) begin
      put(4);
      foreach (exp_q[i]) begin
        dev_tx(c, exp_q[i]);
        if (i == 0)
          t0 = cyc;
      end
      tx_valid[c] = 1'b0;
      chk("burst", 1'b1, cyc - t0 < 1630);
      tick(700);
      cmp_tx(c);
    end
    put(3);
    dev_tx(0, exp_q[0]);
    tx_valid[0] = 1'b0;
    t0 = cyc;
    tick(600);
    dev_tx(0, exp_q[1]);
    chk("gap", 1'b1, (cyc - t0) inside {[1080:1100]});
    tick(100);
    tx_permit_n = 1'b1;
    tx_data[0] = exp_q[2];
    tick(2500);
    chk("permit_hold", 2, h1.got_q.size());
    tx_permit_n = 1'b0;
    t0 = cyc;
    dev_tx(0, exp_q[2]);
    chk("permit_resp", 1'b1, cyc - t0 <= 2160);
    tx_valid[0] = 1'b0;
    tick(700);
    cmp_tx(0);
    for (c = 0; c < 2; c++) begin
      put(6);
      sq = exp_q;
      fork
        foreach (sq[i]) begin
          if (c)
            h2.send(sq[i], 1'b1, 1'b0);
          else
            h1.send(sq[i], 1'b1, 1'b1);
        end
      join_none
      tick(5000);
      if (c == 0)
        chk("request_full", 1'b1, rts_w);
      drain(c, 6);
    end
    put(9);
    foreach (exp_q[i]) h1.send(exp_q[i], 1'b1, 1'b0);
    exp_q.pop_back();
    tick(50);
    chk("overrun", 1, n_ov);
    drain(0, 8);
    h1.send(8'h5a, 1'b0, 1'b1);
    tick(50);
    chk("framing", 1, n_fr);
    chk("framing_drop", 1'b0, rx_valid[0]);
    tick(1500);
    n_to = 0;
    put(1);
    h1.send(exp_q[0], 1'b1, 1'b1);
    tick(900);
    chk("timeout_early", 0, n_to);
    tick(300);
    chk("timeout", 1, n_to);
    drain(0, 1);
    module_reset_n = 1'b0;
    tick(5);
    chk("host_reset_cfg", {16'h01b2, 8'h0c, 8'h04}, cfg_active);
    chk("host_reset_boot", 1'b0, boot_done);
    module_reset_n = 1'b1;
    tick(60);
    chk("reboot", 1'b1, boot_done);
    chk("ch2_errors", 0, n_e2);
    chk("ch2_timeout", 1, n_t2);
    test_done;
  end
  initial begin
    #2000000;
    failures++;
    test_done;
  end
endmodule
`default_nettype wire

// [sim/hufc_top_sva.sv]
`timescale 1ns/1ps
`default_nettype none
`include "hufc_params.svh"
module hufc_top_sva
  import hufc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic tx_permit_n,
  input wire logic ch1_serial_out,
  input wire logic ch1_serial_out_oe,
  input wire logic ch2_serial_out,
  input wire logic ch2_serial_out_oe,
  input wire logic rx_request_n,
  input wire logic rx_request_n_oe,
  input wire logic cfg_load,
  input wire hufc_cfg_t cfg_in,
  input wire logic cfg_reject,
  input wire hufc_cfg_t cfg_active,
  input wire logic [`HUFC_CHANNELS-1:0] tx_valid,
  input wire logic [`HUFC_CHANNELS-1:0] tx_ready,
  input wire logic [`HUFC_CHANNELS-1:0] rx_valid,
  input wire hufc_err_t [`HUFC_CHANNELS-1:0] rx_err,
  input wire logic boot_done
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  a_pins_wait_boot: assert property (
    !boot_done |-> !ch1_serial_out_oe && !rx_request_n_oe && rx_request_n)
    else $error("pins driven before boot");
  a_pins_attach: assert property (
    $rose(boot_done) |=> ch1_serial_out_oe && ch2_serial_out_oe)
    else $error("pins not attached after boot");
  a_permit_blocks: assert property (
    tx_permit_n [*3] |-> !tx_ready[0])
    else $error("transmit offered while permit high");
  a_frame_whole: assert property (
    tx_valid[0] && tx_ready[0] |=> !tx_ready[0] [*8])
    else $error("transmitter free during frame");
  a_start_ch1: assert property (
    tx_valid[0] && tx_ready[0] |-> ##4 !ch1_serial_out)
    else $error("no start bit on channel 1");
  a_start_ch2: assert property (
    tx_valid[1] && tx_ready[1] |-> ##4 !ch2_serial_out)
    else $error("no start bit on channel 2");
  a_request_room: assert property (
    (boot_done && !rx_valid[0]) [*3] |-> !rx_request_n)
    else $error("request high with empty buffer");
  a_overrun_pulse: assert property (
    rx_err[0].overrun |=> !rx_err[0].overrun)
    else $error("overrun longer than one cycle");
  a_framing_pulse: assert property (
    rx_err[0].framing |=> !rx_err[0].framing)
    else $error("framing longer than one cycle");
  a_cfg_range: assert property (
    cfg_load && (cfg_in.bit_div < `HUFC_DIV_MIN ||
      cfg_in.bit_div > `HUFC_DIV_MAX) |=> cfg_reject)
    else $error("bad divisor accepted");
  a_cfg_keep: assert property (
    cfg_reject |-> $stable(cfg_active))
    else $error("rejected setting changed config");
  a_cfg_default: assert property (
    $fell(rst) |-> cfg_active.bit_div == `HUFC_DIV_DEFAULT &&
      cfg_active.gap_chars == `HUFC_GAP_DEFAULT)
    else $error("config not default after reset");
endmodule
bind hufc_top hufc_top_sva hufc_top_sva_i (.clk_sys(clk_sys), .rst(rst),
  .tx_permit_n(tx_permit_n), .ch1_serial_out(ch1_serial_out),
  .ch1_serial_out_oe(ch1_serial_out_oe), .ch2_serial_out(ch2_serial_out),
  .ch2_serial_out_oe(ch2_serial_out_oe), .rx_request_n(rx_request_n),
  .rx_request_n_oe(rx_request_n_oe), .cfg_load(cfg_load), .cfg_in(cfg_in),
  .cfg_reject(cfg_reject), .cfg_active(cfg_active), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_err(rx_err),
  .boot_done(boot_done));
`default_nettype wire
